//--- rtl/rbts_regs.svh
`ifndef RBTS_REGS_SVH
`define RBTS_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RBTS_A_CFG 8'h00
`define RBTS_A_CMD 8'h04
`define RBTS_A_DEPTH 8'h08
`define RBTS_A_DMIN 8'h0c
`define RBTS_A_DMAX 8'h10
`define RBTS_A_DDEF 8'h14
`define RBTS_A_COUNT 8'h18
`define RBTS_A_FREE 8'h1c
`define RBTS_A_RSVD 8'h20
`define RBTS_A_TIME 8'h24
`define RBTS_A_STAT 8'h28
`define RBTS_A_RIDX 8'h2c
`define RBTS_A_RVAL 8'h30
`define RBTS_A_RTS 8'h34
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RBTS_CFG_FEED_LO 0
`define RBTS_CFG_FEED_HI 1
`define RBTS_CFG_TSFMT 2
`define RBTS_CFG_AUTO 3
`define RBTS_CFG_FILL 4
`define RBTS_CMD_TSRST 0
`define RBTS_CMD_CLEAR 1
`define RBTS_CMD_INIT 2
`define RBTS_CMD_ABORT 3
// ----------------------------------------
// Limits, reset values, timing
// ----------------------------------------
`define RBTS_DEPTH_MIN 12'h001
`define RBTS_DEPTH_MAX 12'h9c4
`define RBTS_DEPTH_DEF 12'h064
`define RBTS_REC_BYTES 32'h0000_0008
`define RBTS_CLK_NS 10
`define RBTS_TICK_NS 1000
`define RBTS_TICK_CYC (`RBTS_TICK_NS / `RBTS_CLK_NS)
`endif

//--- rtl/rbts_pkg.sv
package rbts_pkg;
    // Feed selector codes
    typedef enum logic [1:0] {
        RBTS_FEED_RAW = 2'h0,
        RBTS_FEED_MATH = 2'h1,
        RBTS_FEED_LIMIT = 2'h2
    } rbts_feed_e;
    // Sequencer state
    typedef enum logic [1:0] {
        RBTS_SEQ_IDLE = 2'b01,
        RBTS_SEQ_RUN = 2'b10
    } rbts_seq_e;
    // Storage state
    typedef enum logic [2:0] {
        RBTS_ST_OFF = 3'b001,
        RBTS_ST_ARMED = 3'b010,
        RBTS_ST_STORE = 3'b100
    } rbts_st_e;
    // One reading from the measurement engine, all feeds at once
    typedef struct packed {
        logic [31:0] raw;
        logic [31:0] math_result_feed;
        logic [31:0] limit_result_feed;
    } rbts_rec_s;
endpackage

//--- rtl/rbts_top.sv
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "rbts_regs.svh"
// Operation
// R1: timestamp reset command zeroes counter immediately
// R2: counter is zero after power-up reset
// R3: auto reset zeroes counter on idle exit
// R4: timestamp read returns counter, unchanged
// R5: depth accepts 1..2500, default 100
// R6: clear discards records; new run overwrites
// R7: count register shows stored records
// R8: free bytes and reserved bytes readable
// R9: feed selects raw, math or limit
// R10: feed change refused while storing
// R11: fill_once arms; storing starts on idle exit
// R12: depth reached stops storage, drops armed
// R13: storage_off stores no records
// R14: from-first timestamps relative to first record
// R15: between timestamps relative to previous record
// R16: every stored record readable by host
// R17: abort returns to idle; rerun is fresh
// R18: count zeroed on clear and run start
// R19: timestamp is free-running microsecond counter
module rbts_top (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_idle_exit,
    input wire logic i_seq_done,
    input wire logic i_rec_valid,
    input wire rbts_pkg::rbts_rec_s i_rec,
    output logic o_armed,
    output logic o_running
);
    localparam int unsigned NREC = 2500;
    localparam logic [6:0] TICK_LAST = 7'(`RBTS_TICK_CYC - 1);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic wr_pend_reg, tsfmt_reg, auto_reg, fill_reg;
    logic [7:0] waddr_reg;
    logic [1:0] feed_reg;
    logic [11:0] depth_reg, count_reg, widx_reg, ridx_reg;
    logic [31:0] ts_reg, first_ts_reg, prev_ts_reg;
    logic [6:0] presc_reg;
    logic [31:0] mem_val [0:NREC-1];
    logic [31:0] mem_ts [0:NREC-1];
    rbts_pkg::rbts_seq_e seq_reg;
    rbts_pkg::rbts_st_e st_reg;
    logic addr_ok, wen, cmd_wr, cfg_wr, cmd_tsrst, cmd_clear, cmd_init;
    logic cmd_abort, idle_exit, store_en, last_rec;
    logic [31:0] cur_val, rec_ts, rd_word;

    // Address phase accepted on a NONSEQ or SEQ with hready
    assign addr_ok = i_hsel && i_hready && i_htrans[1];

    // Capture a write address phase for the following data phase
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_pend_reg <= 1'b0;
            waddr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && i_hwrite;
            if (addr_ok) begin
                waddr_reg <= i_haddr[7:0];
            end
        end
    end

    assign wen = wr_pend_reg;
    assign cmd_wr = wen && (waddr_reg == `RBTS_A_CMD);
    assign cfg_wr = wen && (waddr_reg == `RBTS_A_CFG);
    assign cmd_tsrst = cmd_wr && i_hwdata[`RBTS_CMD_TSRST];
    assign cmd_clear = cmd_wr && i_hwdata[`RBTS_CMD_CLEAR];
    assign cmd_init = cmd_wr && i_hwdata[`RBTS_CMD_INIT];
    assign cmd_abort = cmd_wr && i_hwdata[`RBTS_CMD_ABORT];

    // Always ready, always OKAY
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (i_haddr[7:0])
            `RBTS_A_CFG: begin
                rd_word = {27'h0, fill_reg, auto_reg, tsfmt_reg, feed_reg};
            end
            `RBTS_A_DEPTH: rd_word = {20'h0, depth_reg};
            `RBTS_A_DMIN: rd_word = {20'h0, `RBTS_DEPTH_MIN}; // R5
            `RBTS_A_DMAX: rd_word = {20'h0, `RBTS_DEPTH_MAX}; // R5
            `RBTS_A_DDEF: rd_word = {20'h0, `RBTS_DEPTH_DEF}; // R5
            `RBTS_A_COUNT: rd_word = {20'h0, count_reg}; // R7
            `RBTS_A_FREE: begin
                rd_word = 32'(NREC) * `RBTS_REC_BYTES
                    - {20'h0, count_reg} * `RBTS_REC_BYTES; // R8
            end
            `RBTS_A_RSVD: rd_word = {20'h0, depth_reg} * `RBTS_REC_BYTES; // R8
            `RBTS_A_TIME: rd_word = ts_reg; // R4
            `RBTS_A_STAT: begin
                rd_word = {30'h0, seq_reg == rbts_pkg::RBTS_SEQ_RUN,
                    st_reg != rbts_pkg::RBTS_ST_OFF};
            end
            `RBTS_A_RIDX: rd_word = {20'h0, ridx_reg};
            `RBTS_A_RVAL: begin
                if (ridx_reg < count_reg) begin
                    rd_word = mem_val[ridx_reg]; // R16
                end
            end
            `RBTS_A_RTS: begin
                if (ridx_reg < count_reg) begin
                    rd_word = mem_ts[ridx_reg]; // R16
                end
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase, stands in data phase
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_ok && !i_hwrite) begin
            o_hrdata <= rd_word;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            feed_reg <= 2'h0;
            tsfmt_reg <= 1'b0;
            auto_reg <= 1'b0;
            fill_reg <= 1'b0;
        end else if (cfg_wr) begin
            if (st_reg != rbts_pkg::RBTS_ST_STORE &&
                i_hwdata[`RBTS_CFG_FEED_HI:`RBTS_CFG_FEED_LO] != 2'h3) begin
                feed_reg <= i_hwdata[`RBTS_CFG_FEED_HI:`RBTS_CFG_FEED_LO]; // R10
            end
            tsfmt_reg <= i_hwdata[`RBTS_CFG_TSFMT];
            auto_reg <= i_hwdata[`RBTS_CFG_AUTO];
            fill_reg <= i_hwdata[`RBTS_CFG_FILL];
        end
    end

    // Depth accepts only the legal range
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            depth_reg <= `RBTS_DEPTH_DEF; // R5
        end else if (wen && waddr_reg == `RBTS_A_DEPTH) begin
            if (i_hwdata[31:0] >= {20'h0, `RBTS_DEPTH_MIN} &&
                i_hwdata[31:0] <= {20'h0, `RBTS_DEPTH_MAX}) begin
                depth_reg <= i_hwdata[11:0]; // R5
            end
        end
    end

    // Read index for walking the stored records
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ridx_reg <= 12'h000;
        end else if (wen && waddr_reg == `RBTS_A_RIDX) begin
            ridx_reg <= i_hwdata[11:0]; // R16
        end
    end

    // ----------------------------------------
    // Sequencer idle state
    // ----------------------------------------
    assign idle_exit = (seq_reg == rbts_pkg::RBTS_SEQ_IDLE) &&
        (cmd_init || i_idle_exit);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seq_reg <= rbts_pkg::RBTS_SEQ_IDLE;
        end else begin
            unique case (seq_reg)
                rbts_pkg::RBTS_SEQ_IDLE: begin
                    if (idle_exit) begin
                        seq_reg <= rbts_pkg::RBTS_SEQ_RUN;
                    end
                end
                rbts_pkg::RBTS_SEQ_RUN: begin
                    if (cmd_abort || i_seq_done) begin
                        seq_reg <= rbts_pkg::RBTS_SEQ_IDLE; // R17
                    end
                end
                default: seq_reg <= rbts_pkg::RBTS_SEQ_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Timestamp counter
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            presc_reg <= 7'h00;
            ts_reg <= 32'h0000_0000; // R2
        end else begin
            if (presc_reg == TICK_LAST) begin
                presc_reg <= 7'h00;
            end else begin
                presc_reg <= presc_reg + 7'h01; // R19
            end
            if (cmd_tsrst) begin
                ts_reg <= 32'h0000_0000; // R1
            end else if (idle_exit && auto_reg) begin
                ts_reg <= 32'h0000_0000; // R3
            end else if (presc_reg == TICK_LAST) begin
                ts_reg <= ts_reg + 32'h0000_0001; // R19
            end
        end
    end

    // ----------------------------------------
    // Storage control
    // ----------------------------------------
    assign store_en = (st_reg == rbts_pkg::RBTS_ST_STORE) && i_rec_valid &&
        !idle_exit && !cmd_clear; // R13
    assign last_rec = (count_reg + 12'h001) >= depth_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= rbts_pkg::RBTS_ST_OFF;
        end else if (cfg_wr && !i_hwdata[`RBTS_CFG_FILL]) begin
            st_reg <= rbts_pkg::RBTS_ST_OFF; // R13
        end else begin
            unique case (st_reg)
                rbts_pkg::RBTS_ST_OFF: begin
                    if (cfg_wr) begin
                        st_reg <= rbts_pkg::RBTS_ST_ARMED; // R11
                    end
                end
                rbts_pkg::RBTS_ST_ARMED: begin
                    if (idle_exit) begin
                        st_reg <= rbts_pkg::RBTS_ST_STORE; // R11
                    end
                end
                rbts_pkg::RBTS_ST_STORE: begin
                    if (store_en && last_rec) begin
                        st_reg <= rbts_pkg::RBTS_ST_OFF; // R12
                    end
                end
                default: st_reg <= rbts_pkg::RBTS_ST_OFF;
            endcase
        end
    end

    // Count and write position; a new run restarts from the start
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_reg <= 12'h000;
            widx_reg <= 12'h000;
        end else if (cmd_clear) begin
            count_reg <= 12'h000; // R6 R18
            widx_reg <= 12'h000;
        end else if (idle_exit && st_reg != rbts_pkg::RBTS_ST_OFF) begin
            count_reg <= 12'h000; // R18 R17
            widx_reg <= 12'h000; // R6
        end else if (store_en) begin
            count_reg <= count_reg + 12'h001; // R7
            widx_reg <= widx_reg + 12'h001;
        end
    end

    // Feed selection
    always_comb begin
        unique case (feed_reg)
            rbts_pkg::RBTS_FEED_MATH: cur_val = i_rec.math_result_feed; // R9
            rbts_pkg::RBTS_FEED_LIMIT: cur_val = i_rec.limit_result_feed; // R9
            default: cur_val = i_rec.raw; // R9
        endcase
    end

    // Timestamp of the record in the chosen format
    always_comb begin
        if (count_reg == 12'h000) begin
            rec_ts = 32'h0000_0000;
        end else if (tsfmt_reg) begin
            rec_ts = ts_reg - prev_ts_reg; // R15
        end else begin
            rec_ts = ts_reg - first_ts_reg; // R14
        end
    end

    // Reference times for the timestamp formats
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            first_ts_reg <= 32'h0000_0000;
            prev_ts_reg <= 32'h0000_0000;
        end else if (store_en) begin
            if (count_reg == 12'h000) begin
                first_ts_reg <= ts_reg; // R14
            end
            prev_ts_reg <= ts_reg; // R15
        end
    end

    // Record storage
    always_ff @(posedge i_clk) begin
        if (store_en) begin
            mem_val[widx_reg] <= cur_val;
            mem_ts[widx_reg] <= rec_ts;
        end
    end

    // ----------------------------------------
    // Indicators
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_armed <= 1'b0;
            o_running <= 1'b0;
        end else begin
            o_armed <= st_reg != rbts_pkg::RBTS_ST_OFF; // R11 R12
            o_running <= seq_reg == rbts_pkg::RBTS_SEQ_RUN;
        end
    end
endmodule

//--- testbench/rbts_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module rbts_checker (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic i_idle_exit,
    input wire logic i_seq_done,
    input wire logic i_rec_valid,
    input wire logic o_armed,
    input wire logic o_running
);
    logic taken;
    logic [2:0] wr_age;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Transfer accepted at this edge
    assign taken = i_hsel && i_hready && i_htrans[1];
    // Cycles since the last write was taken, saturating
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_age <= 3'h7;
        end else if (taken && i_hwrite) begin
            wr_age <= 3'h0;
        end else if (wr_age != 3'h7) begin
            wr_age <= wr_age + 3'h1;
        end
    end
    sequence s_wr_recent;
        wr_age < 3'h5;
    endsequence
    sequence s_arm_quiet;
        o_armed && !i_rec_valid && !$past(i_rec_valid) &&
            !$past(i_rec_valid, 2) && !$past(i_rec_valid, 3) &&
            wr_age == 3'h7;
    endsequence
    AST_READY: assert property (o_hreadyout)
        else $error("hreadyout low");
    AST_RESP: assert property (!o_hresp)
        else $error("error response");
    AST_HRDATA: assert property (!$past(taken && !i_hwrite) |->
        $stable(o_hrdata)) else $error("read data moved");
    AST_ARM_RISE: assert property ($rose(o_armed) |-> s_wr_recent)
        else $error("armed without write");
    AST_ARM_HOLD: assert property (s_arm_quiet |=> o_armed)
        else $error("armed dropped early");
    AST_RUN_SET: assert property (i_idle_exit && !i_seq_done &&
        wr_age == 3'h7 |-> ##2 o_running) else $error("run not set");
    AST_RUN_CLR: assert property (i_seq_done && !i_idle_exit &&
        wr_age == 3'h7 |-> ##2 !o_running) else $error("run not cleared");
    AST_RUN_HOLD: assert property (o_running && !i_seq_done &&
        !$past(i_seq_done) && wr_age == 3'h7 |=> o_running)
        else $error("run dropped");
endmodule

bind rbts_top rbts_checker u_chk (
    .i_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_idle_exit,
    .i_seq_done, .i_rec_valid, .o_armed, .o_running
);

//--- testbench/rbts_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host bus master model
// ----------------------------------------
module rbts_host (
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [31:0] o_hwdata
);
    // Idle bus at time zero
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hwdata = 32'h0;
    end
    // One single word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_clk);
        o_hsel <= 1'b1;
        o_haddr <= {24'h0, a};
        o_htrans <= 2'h2;
        o_hwrite <= w;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= wd;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        rd = i_hrdata;
    endtask
endmodule

//--- testbench/test_reading_buffer_timestamp.sv
`timescale 1ns/1ns
`include "rbts_regs.svh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module test_reading_buffer_timestamp;
    logic i_clk, i_reset_n, hsel, hwrite, hready, hresp;
    logic idle_exit, seq_done, rec_valid, armed, running;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    rbts_pkg::rbts_rec_s rec;
    integer seed = 32'hf801879c;
    integer err_total = 0;
    integer checks_done = 0;
    integer cyc = 0;
    logic [31:0] exp_v [0:15];
    logic [31:0] exp_t [0:15];
    logic [7:0] ra [0:9] = '{8'h0c, 8'h10, 8'h14, 8'h08, 8'h18,
        8'h1c, 8'h20, 8'h24, 8'h28, 8'h3c};
    logic [31:0] re [0:9] = '{32'h1, 32'h9c4, 32'h64, 32'h64, 32'h0,
        32'h4e20, 32'h320, 32'h0, 32'h0, 32'h0};
    logic [1:0] f1;
    rbts_top dut (.i_clk, .i_reset_n, .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_idle_exit(idle_exit),
        .i_seq_done(seq_done), .i_rec_valid(rec_valid), .i_rec(rec),
        .o_armed(armed), .o_running(running));
    rbts_host u_host (.i_clk, .i_hready(hready), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hwdata(hwdata));
    // Clock and hang guard
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rv);
    endtask
    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, rv);
        check(n, rv, e);
    endtask
    task automatic settle;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic pulse(input int w);
        @(posedge i_clk);
        if (w == 0) rec <= {$random(seed), $random(seed), $random(seed)};
        rec_valid <= (w == 0);
        idle_exit <= (w == 1);
        seq_done <= (w == 2);
        @(posedge i_clk);
        {rec_valid, idle_exit, seq_done} <= 3'h0;
    endtask
    function automatic logic [31:0] pick(input logic [1:0] f);
        return f == 2'h0 ? rec.raw : f == 2'h1 ? rec.math_result_feed :
            rec.limit_result_feed;
    endfunction
    // One storage run: arm, start, feed records, read back
    task automatic run(input logic [1:0] f, input logic fm, au,
                       input int n, input logic by_cmd);
        int m;
        int acc;
        acc = 0;
        wr(`RBTS_A_DEPTH, n);
        wr(`RBTS_A_CFG, {27'h0, 1'b1, au, fm, f});
        settle();
        check("armed", {31'h0, armed}, 32'h1);
        pulse(0);
        if (by_cmd) wr(`RBTS_A_CMD, 32'h4);
        else pulse(1);
        u_host.xfer(1'b0, `RBTS_A_TIME, 32'h0, rv);
        check("ts_idle", {31'h0, au ? rv <= 1 : rv >= 2}, 32'h1);
        check("running", {31'h0, running}, 32'h1);
        wr(`RBTS_A_CFG, {28'h1, au, fm, f == 2'h2 ? 2'h0 : f + 2'h1});
        rdc("feed", `RBTS_A_CFG, {28'h1, au, fm, f});
        for (int k = 0; k < n + 2; k++) begin
            m = 1 + $unsigned($random(seed)) % 3;
            if (k > 0) acc += m;
            repeat (100 * m - 2) @(posedge i_clk);
            pulse(0);
            exp_v[k] = pick(f);
            exp_t[k] = k == 0 ? 0 : fm ? m : acc;
        end
        settle();
        check("armed_end", {31'h0, armed}, 32'h0);
        rdc("count", `RBTS_A_COUNT, n);
        rdc("free", `RBTS_A_FREE, (2500 - n) * 8);
        rdc("rsvd", `RBTS_A_RSVD, n * 8);
        for (int k = 0; k < n; k++) begin
            wr(`RBTS_A_RIDX, k);
            rdc("value", `RBTS_A_RVAL, exp_v[k]);
            rdc("stamp", `RBTS_A_RTS, exp_t[k]);
        end
        if (by_cmd) wr(`RBTS_A_CMD, 32'h8);
        else pulse(2);
        settle();
        check("stopped", {31'h0, running}, 32'h0);
        $display("run done");
    endtask
    // Main sequence
    initial begin
        {i_reset_n, rec_valid, idle_exit, seq_done} = 4'h0;
        rec = '0;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 10; i++) rdc("reset", ra[i], re[i]);
        wr(`RBTS_A_DEPTH, 32'h0);
        rdc("depth_lo", `RBTS_A_DEPTH, 32'h64);
        wr(`RBTS_A_DEPTH, 32'h9c5);
        rdc("depth_hi", `RBTS_A_DEPTH, 32'h64);
        wr(`RBTS_A_DEPTH, 32'h9c4);
        rdc("depth_max", `RBTS_A_DEPTH, 32'h9c4);
        $display("limits done");
        repeat (300) @(posedge i_clk);
        wr(`RBTS_A_CMD, 32'h1);
        u_host.xfer(1'b0, `RBTS_A_TIME, 32'h0, rv);
        check("ts_reset", {31'h0, rv <= 1}, 32'h1);
        $display("timestamp done");
        f1 = 2'($unsigned($random(seed)) % 3);
        run(f1, 1'b0, 1'b1, 3 + $unsigned($random(seed)) % 4, 1'b0);
        run(f1 == 2'h2 ? 2'h0 : f1 + 2'h1, 1'b1, 1'b0, 5, 1'b1);
        run(f1 == 2'h0 ? 2'h2 : f1 - 2'h1, 1'($random(seed)), 1'b1, 1, 1'b0);
        wr(`RBTS_A_CMD, 32'h2);
        rdc("cleared", `RBTS_A_COUNT, 32'h0);
        wr(`RBTS_A_CFG, 32'h10);
        settle();
        check("rearm", {31'h0, armed}, 32'h1);
        wr(`RBTS_A_CFG, 32'h0);
        settle();
        check("off", {31'h0, armed}, 32'h0);
        pulse(1);
        pulse(0);
        pulse(0);
        rdc("off_count", `RBTS_A_COUNT, 32'h0);
        pulse(2);
        $display("storage off done");
        give_verdict();
    end
endmodule
